//--- design/arc_regs.sv
// register-side logic of a successive approximation converter.
// assumes an avalon-mm master on MCLK and a converter core that pulses
// CORE_DONE with CORE_RESULT for one MCLK cycle per finished conversion.

// How it works
// - 10-bit mode: result_high bits 1:0 hold result bits 9:8.
// - 8-bit mode: result_high reads as zero.
// - results load on completion unless compare enabled and condition false.
// - 10-bit mode: reading result_high locks results until result_low is read or the mode changes.
// - a completion during the lock is discarded.
// - 8-bit mode: reads create no lock.
// - a mode change makes stored results invalid until the next completion.
// - result_low holds low eight bits of 10-bit or the whole 8-bit result.
// - compare high bits used in 10-bit mode only.
// - compare low eight bits compared in both modes.
// - config bit 7 selects high-speed or low-power operating point.
// - config bits 6:5 divide the selected clock by 1, 2, 4 or 8.
// - config bit 4 selects short or long sample time.
// - config bits 3:2: 00 is 8-bit, 10 is 10-bit, others reserved.
// - config bits 1:0 select bus, bus/2, alternate or async clock.
// - bank0 bit n detaches pin of channel n, channels 0 to 7.
// - bank1 bit n detaches pin of channel 8+n, channels 8 to 15.
// - compare holds when below, or when greater-equal with option set.
// - transfer to result registers sets the completion flag.
// - detached pin: output tri-stated, input reads zero, pullup off.
// - after reset the clock source is the bus clock.
module arc_regs #(
    parameter int NCH = 16
) (
    input  wire logic              MCLK,
    input  wire logic              RST,
    input  wire logic [4:0]        AVS_ADDRESS,
    input  wire logic              AVS_READ,
    input  wire logic              AVS_WRITE,
    input  wire logic [31:0]       AVS_WRITEDATA,
    input  wire logic [3:0]        AVS_BYTEENABLE,
    output logic      [31:0]       AVS_READDATA,
    output logic                   AVS_WAITREQUEST,
    output logic                   AVS_RESPONSE_ERR,
    input  wire logic              CORE_DONE,
    input  wire logic [9:0]        CORE_RESULT,
    output logic                   LOW_POWER_SELECT,
    output logic      [1:0]        CLOCK_DIVIDE_SELECT,
    output logic                   LONG_SAMPLE_SELECT,
    output logic      [1:0]        CONVERSION_MODE,
    output logic      [1:0]        INPUT_CLOCK_SELECT,
    output logic                   RESULT_VALID,
    input  wire logic              ALTERNATE_CLOCK,
    input  wire logic              ASYNC_CONVERTER_CLOCK,
    output logic                   CONVERTER_CLOCK,
    input  wire logic [NCH-1:0]    PORT_OUT,
    input  wire logic [NCH-1:0]    PORT_OE,
    input  wire logic [NCH-1:0]    PORT_PULLUP,
    input  wire logic [NCH-1:0]    PIN_IN,
    output logic      [NCH-1:0]    PIN_OUT,
    output logic      [NCH-1:0]    PIN_OE,
    output logic      [NCH-1:0]    PIN_PULLUP,
    output logic      [NCH-1:0]    PORT_IN
);

    // ==========================================================
    // registers
    logic [7:0]     config_r;
    logic [7:0]     cmp_high_r;
    logic [7:0]     cmp_low_r;
    logic [7:0]     bank0_r;
    logic [7:0]     bank1_r;
    logic           cmp_en_r;
    logic           cmp_ge_r;
    logic           conversion_complete_flag_r;
    logic [9:0]     result_r;
    logic           lock_r;
    logic           valid_r;
    logic           wait_r;
    logic [31:0]    rdata_r;
    logic           err_r;

    logic           access;
    logic           take;
    logic           early;
    logic           wr_take;
    logic           rd_take;
    logic           mode10;
    logic [9:0]     cmp_val;
    logic [9:0]     res_cmp;
    logic           cond;
    logic           load;
    logic [7:0]     wr_byte;
    logic [7:0]     cfg_nxt;
    logic           mapped;

    assign access  = AVS_READ | AVS_WRITE;
    // first edge of a request latches read data, the second is the answer edge
    // where writes and read side effects land, so both match what the master sees
    assign early   = access & ~wait_r;
    assign take    = access & wait_r;
    assign wr_take = take & AVS_WRITE;
    assign rd_take = take & AVS_READ;
    assign wr_byte = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : 8'h00;
    assign mode10  = (config_r[arc_pkg::CFG_MODE_LSB +: 2] == arc_pkg::MODE_10BIT);
    assign mapped  = (AVS_ADDRESS[1:0] == 2'h0);

    // ==========================================================
    // bus handshake
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= access & ~wait_r;
        end
    end

    assign AVS_WAITREQUEST = access & wait_r ? 1'b0 : access;

    // ==========================================================
    // writable registers; byte lane 0 only
    always_comb begin
        cfg_nxt = config_r;
        if (wr_take && AVS_BYTEENABLE[0] && AVS_ADDRESS == arc_pkg::OFF_CONFIG) begin
            cfg_nxt = AVS_WRITEDATA[7:0];
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            config_r   <= arc_pkg::RST_CONFIG;
            cmp_high_r <= arc_pkg::RST_BYTE;
            cmp_low_r  <= arc_pkg::RST_BYTE;
            bank0_r    <= arc_pkg::RST_BYTE;
            bank1_r    <= arc_pkg::RST_BYTE;
            cmp_en_r   <= 1'b0;
            cmp_ge_r   <= 1'b0;
        end else begin
            config_r <= cfg_nxt;
            if (wr_take && AVS_BYTEENABLE[0]) begin
                case (AVS_ADDRESS)
                    arc_pkg::OFF_CMP_HIGH:  cmp_high_r <= {6'h00, wr_byte[1:0]};
                    arc_pkg::OFF_CMP_LOW:   cmp_low_r  <= wr_byte;
                    arc_pkg::OFF_PIN_BANK0: bank0_r    <= wr_byte;
                    arc_pkg::OFF_PIN_BANK1: bank1_r    <= wr_byte;
                    arc_pkg::OFF_CMP_CTRL: begin
                        cmp_en_r <= wr_byte[arc_pkg::CC_ENABLE_BIT];
                        cmp_ge_r <= wr_byte[arc_pkg::CC_GE_BIT];
                    end
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // compare and result transfer
    always_comb begin
        cmp_val = mode10 ? {cmp_high_r[1:0], cmp_low_r}
                         : {2'b00, cmp_low_r};
        res_cmp = mode10 ? CORE_RESULT : {2'b00, CORE_RESULT[7:0]};
        cond    = cmp_ge_r ? (res_cmp >= cmp_val) : (res_cmp < cmp_val);
        load    = CORE_DONE && !lock_r && (!cmp_en_r || cond);
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            result_r <= 10'h000;
            valid_r  <= 1'b0;
        end else if (load) begin
            result_r <= mode10 ? CORE_RESULT : {2'b00, CORE_RESULT[7:0]};
            valid_r  <= 1'b1;
        end else if (cfg_nxt[arc_pkg::CFG_MODE_LSB +: 2] != config_r[arc_pkg::CFG_MODE_LSB +: 2]) begin
            valid_r  <= 1'b0;
        end
    end

    // lock is armed by a high read in 10-bit mode, released by a low read
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            lock_r <= 1'b0;
        end else if (rd_take && AVS_ADDRESS == arc_pkg::OFF_RES_LOW) begin
            lock_r <= 1'b0;
        end else if (cfg_nxt[arc_pkg::CFG_MODE_LSB +: 2] != CONVERSION_MODE) begin
            // a lock left from 10-bit mode must not hold back 8-bit results
            lock_r <= 1'b0;
        end else if (rd_take && AVS_ADDRESS == arc_pkg::OFF_RES_HIGH && mode10) begin
            lock_r <= 1'b1;
        end
    end

    // completion flag: set wins over the clear by a compare-control write
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            conversion_complete_flag_r <= 1'b0;
        end else if (load) begin
            conversion_complete_flag_r <= 1'b1;
        end else if (rd_take && AVS_ADDRESS == arc_pkg::OFF_RES_LOW) begin
            conversion_complete_flag_r <= 1'b0;
        end else if (wr_take && AVS_ADDRESS == arc_pkg::OFF_CMP_CTRL) begin
            conversion_complete_flag_r <= 1'b0;
        end
    end

    // ==========================================================
    // read data
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            rdata_r <= 32'h0000_0000;
            err_r   <= 1'b0;
        end else if (early) begin
            rdata_r <= 32'h0000_0000;
            err_r   <= 1'b0;
            if (AVS_READ) begin
                case (AVS_ADDRESS)
                    arc_pkg::OFF_RES_HIGH:
                        rdata_r[1:0] <= mode10 ? result_r[9:8] : 2'b00;
                    arc_pkg::OFF_RES_LOW:   rdata_r[7:0] <= result_r[7:0];
                    arc_pkg::OFF_CMP_HIGH:  rdata_r[7:0] <= cmp_high_r;
                    arc_pkg::OFF_CMP_LOW:   rdata_r[7:0] <= cmp_low_r;
                    arc_pkg::OFF_CONFIG:    rdata_r[7:0] <= config_r;
                    arc_pkg::OFF_PIN_BANK0: rdata_r[7:0] <= bank0_r;
                    arc_pkg::OFF_PIN_BANK1: rdata_r[7:0] <= bank1_r;
                    arc_pkg::OFF_CMP_CTRL:
                        rdata_r[2:0] <= {conversion_complete_flag_r, cmp_ge_r, cmp_en_r};
                    default: err_r <= 1'b1;
                endcase
            end else if (!mapped || AVS_ADDRESS > arc_pkg::OFF_CMP_CTRL) begin
                err_r <= 1'b1;
            end
        end
    end

    assign AVS_READDATA     = rdata_r;
    assign AVS_RESPONSE_ERR = err_r;
    assign RESULT_VALID     = valid_r;

    // ==========================================================
    // configuration outputs
    assign LOW_POWER_SELECT    = config_r[arc_pkg::CFG_LOW_POWER_BIT];
    assign CLOCK_DIVIDE_SELECT = config_r[arc_pkg::CFG_DIV_LSB +: 2];
    assign LONG_SAMPLE_SELECT  = config_r[arc_pkg::CFG_LONG_SMP_BIT];
    assign CONVERSION_MODE     = config_r[arc_pkg::CFG_MODE_LSB +: 2];
    assign INPUT_CLOCK_SELECT  = config_r[arc_pkg::CFG_ICLK_LSB +: 2];

    // ==========================================================
    // converter clock: external sources are sampled, so this is an enable-rate
    // approximation of the real clock tree, limited to below MCLK/2 for the alternate and async sources
    logic [1:0] alt_s;
    logic [1:0] async_s;
    logic       half_r;
    logic       src_prev_r;
    logic       src;
    logic [2:0] div_cnt_r;
    logic [2:0] div_max;
    logic       ck_r;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            alt_s   <= 2'b00;
            async_s <= 2'b00;
            half_r  <= 1'b0;
        end else begin
            alt_s   <= {alt_s[0], ALTERNATE_CLOCK};
            async_s <= {async_s[0], ASYNC_CONVERTER_CLOCK};
            half_r  <= ~half_r;
        end
    end

    always_comb begin
        case (INPUT_CLOCK_SELECT)
            arc_pkg::ICLK_BUS:      src = 1'b1;
            arc_pkg::ICLK_BUS_HALF: src = half_r;
            arc_pkg::ICLK_ALT:      src = alt_s[1] & ~src_prev_r;
            arc_pkg::ICLK_ASYNC:    src = async_s[1] & ~src_prev_r;
            default:                src = 1'b1;
        endcase
        case (CLOCK_DIVIDE_SELECT)
            2'h0:    div_max = 3'h0;
            2'h1:    div_max = 3'h1;
            2'h2:    div_max = 3'h3;
            default: div_max = 3'h7;
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            src_prev_r <= 1'b0;
            div_cnt_r  <= 3'h0;
            ck_r       <= 1'b0;
        end else begin
            src_prev_r <= (INPUT_CLOCK_SELECT == arc_pkg::ICLK_ALT) ? alt_s[1] : async_s[1];
            ck_r       <= 1'b0;
            if (src) begin
                if (div_cnt_r >= div_max) begin
                    div_cnt_r <= 3'h0;
                    ck_r      <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + 3'h1;
                end
            end
        end
    end

    assign CONVERTER_CLOCK = ck_r;

    // ==========================================================
    // pin detach, one entry per channel
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_pin
            logic det;
            if (gi < 8) begin : g_b0
                assign det = bank0_r[gi];
            end else begin : g_b1
                assign det = bank1_r[gi-8];
            end
            assign PIN_OUT[gi]    = PORT_OUT[gi];
            assign PIN_OE[gi]     = PORT_OE[gi] & ~det;
            assign PIN_PULLUP[gi] = PORT_PULLUP[gi] & ~det;
            assign PORT_IN[gi]    = PIN_IN[gi] & ~det;
        end
    endgenerate

    // ==========================================================
    // checks
    lock_blocks_a: assert property (@(posedge MCLK) disable iff (RST)
        lock_r && CORE_DONE |=> $stable(result_r))
        else $error("result changed while locked");
    high_read_lock_a: assert property (@(posedge MCLK) disable iff (RST)
        rd_take && AVS_ADDRESS == arc_pkg::OFF_RES_HIGH && mode10 |=> lock_r)
        else $error("high read did not lock");
    no_lock_8bit_a: assert property (@(posedge MCLK) disable iff (RST)
        !mode10 |-> !lock_r)
        else $error("lock in 8-bit mode");
    low_read_free_a: assert property (@(posedge MCLK) disable iff (RST)
        rd_take && AVS_ADDRESS == arc_pkg::OFF_RES_LOW |=> !lock_r)
        else $error("low read did not release");
    cmp_block_a: assert property (@(posedge MCLK) disable iff (RST)
        CORE_DONE && cmp_en_r && !cond |=> $stable(result_r))
        else $error("failed compare stored result");
    conversion_complete_flag_set_a: assert property (@(posedge MCLK) disable iff (RST)
        load |=> conversion_complete_flag_r && result_r == $past(res_cmp))
        else $error("transfer did not set flag");
    high_zero_a: assert property (@(posedge MCLK) disable iff (RST)
        rd_take && AVS_ADDRESS == arc_pkg::OFF_RES_HIGH && !mode10 |=> AVS_READDATA == 32'h0)
        else $error("high result not zero in 8-bit");
    mode_invalid_a: assert property (@(posedge MCLK) disable iff (RST)
        !load && cfg_nxt[arc_pkg::CFG_MODE_LSB +: 2] != CONVERSION_MODE |=> !valid_r)
        else $error("mode change kept result valid");
    pin_detach_a: assert property (@(posedge MCLK) disable iff (RST)
        bank0_r[0] |-> !PIN_OE[0] && !PORT_IN[0] && !PIN_PULLUP[0])
        else $error("detached pin still driven");
    div_rate_a: assert property (@(posedge MCLK) disable iff (RST)
        ck_r && INPUT_CLOCK_SELECT == arc_pkg::ICLK_BUS && CLOCK_DIVIDE_SELECT == 2'h1
        && $stable(config_r) ##1 $stable(config_r) |-> !ck_r ##1 ck_r)
        else $error("divide by two rate wrong");
    // writes land only at the answer edge
    cfg_write_a: assert property (@(posedge MCLK) disable iff (RST)
        wr_take && AVS_BYTEENABLE[0] && AVS_ADDRESS == arc_pkg::OFF_CONFIG
        |=> {24'h000000, config_r} == ($past(AVS_WRITEDATA) & 32'h0000_00FF))
        else $error("config write did not land");
    bank1_detach_a: assert property (@(posedge MCLK) disable iff (RST)
        bank1_r[7] |-> !PIN_OE[15] && !PORT_IN[15] && !PIN_PULLUP[15])
        else $error("detached high pin still driven");
    result8_high_a: assert property (@(posedge MCLK) disable iff (RST)
        load && !mode10 |=> result_r[9:8] == 2'b00)
        else $error("8-bit result kept upper bits");
    cmp_high_ignored_a: assert property (@(posedge MCLK) disable iff (RST)
        CORE_DONE && !lock_r && !mode10 && cmp_en_r && cmp_ge_r
        && CORE_RESULT[7:0] >= cmp_low_r |=> conversion_complete_flag_r)
        else $error("8-bit compare used high bits");
    conversion_complete_flag_set_wins_a: assert property (@(posedge MCLK) disable iff (RST)
        load && wr_take && AVS_ADDRESS == arc_pkg::OFF_CMP_CTRL |=> conversion_complete_flag_r)
        else $error("flag clear beat the set");

endmodule

//--- inc/arc_pkg.sv
// package for the converter result, compare, configuration and pin-control registers.
// assumes a 32-bit avalon-mm slave with word addressing by byte address.
package arc_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [4:0] OFF_RES_HIGH  = 5'h00;
    localparam logic [4:0] OFF_RES_LOW   = 5'h04;
    localparam logic [4:0] OFF_CMP_HIGH  = 5'h08;
    localparam logic [4:0] OFF_CMP_LOW   = 5'h0C;
    localparam logic [4:0] OFF_CONFIG    = 5'h10;
    localparam logic [4:0] OFF_PIN_BANK0 = 5'h14;
    localparam logic [4:0] OFF_PIN_BANK1 = 5'h18;
    localparam logic [4:0] OFF_CMP_CTRL  = 5'h1C;

    // ==========================================================
    // configuration fields
    localparam int CFG_LOW_POWER_BIT = 7;
    localparam int CFG_DIV_LSB       = 5;
    localparam int CFG_LONG_SMP_BIT  = 4;
    localparam int CFG_MODE_LSB      = 2;
    localparam int CFG_ICLK_LSB      = 0;
    localparam logic [1:0] MODE_8BIT  = 2'h0;
    localparam logic [1:0] MODE_10BIT = 2'h2;
    localparam logic [1:0] ICLK_BUS   = 2'h0;
    localparam logic [1:0] ICLK_BUS_HALF = 2'h1;
    localparam logic [1:0] ICLK_ALT   = 2'h2;
    localparam logic [1:0] ICLK_ASYNC = 2'h3;

    // compare control register fields
    localparam int CC_ENABLE_BIT = 0;
    localparam int CC_GE_BIT     = 1;
    localparam int CC_CONVERSION_COMPLETE_FLAG_BIT   = 2;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_BYTE   = 8'h00;

    // waitrequest is high for this many cycles before each answer
    localparam int WAIT_CYCLES = 1;

endpackage

//--- bench/arc_core_model.sv
// model of the converter core that finishes one conversion per start pulse.
// assumes START is a one-cycle pulse on MCLK and LATENCY is held with it.
module arc_core_model (
    input  wire logic       MCLK,
    input  wire logic       RST,
    input  wire logic       START,
    input  wire logic [3:0] LATENCY,
    input  wire logic [9:0] VALUE,
    output logic            CORE_DONE,
    output logic [9:0]      CORE_RESULT
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_r;
    logic       busy_r;
    logic [9:0] hold_r;

    // ==========================================================
    // conversion engine
    // result lines carry the inverse outside the done cycle, so a late sample is caught
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            wait_r <= 4'h0;
            busy_r <= 1'b0;
            hold_r <= 10'h000;
            CORE_DONE <= 1'b0;
            CORE_RESULT <= 10'h3FF;
        end else begin
            CORE_DONE <= 1'b0;
            CORE_RESULT <= ~hold_r;
            if (START) begin
                busy_r <= 1'b1;
                wait_r <= LATENCY;
                hold_r <= VALUE;
            end else if (busy_r && wait_r == 4'h0) begin
                busy_r <= 1'b0;
                CORE_DONE <= 1'b1;
                CORE_RESULT <= hold_r;
            end else if (busy_r) begin
                wait_r <= wait_r - 4'h1;
            end
        end
    end
endmodule

//--- bench/arc_regs_bench.sv
// self-checking bench for the converter register block.
// assumes the core model beside it and the one-wait avalon slave of the design.
module arc_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK = 1'b0, RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic [4:0]  AVS_ADDRESS = 5'h00;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA;
    logic AVS_WAITREQUEST, CORE_DONE, LOW_POWER_SELECT, LONG_SAMPLE_SELECT, RESULT_VALID;
    logic [1:0] CLOCK_DIVIDE_SELECT, CONVERSION_MODE, INPUT_CLOCK_SELECT;
    logic ALTERNATE_CLOCK = 1'b0, ASYNC_CONVERTER_CLOCK = 1'b0, CONVERTER_CLOCK, START = 1'b0;
    logic [9:0]  CORE_RESULT, VALUE = 10'h000;
    logic [3:0]  LATENCY = 4'h0;
    logic [15:0] PORT_OUT = 16'hA5A5, PORT_OE = 16'hFFFF, PORT_PULLUP = 16'hFFFF;
    logic [15:0] PIN_IN = 16'hFFFF, PIN_OUT, PIN_OE, PIN_PULLUP, PORT_IN;
    logic [7:0]  q;
    logic        AVS_RESPONSE_ERR, e;
    logic [7:0]  cfg_tab [4] = '{8'h00, 8'h35, 8'hCA, 8'hFF};
    logic [7:0]  clk_cfg [7] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h01, 8'h02, 8'h03};
    int          clk_exp [7] = '{96, 48, 24, 12, 48, 24, 16};
    int bad_count = 0, checks = 0, cyc = 0;

    arc_regs #(.NCH(16)) uut (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .AVS_RESPONSE_ERR(AVS_RESPONSE_ERR), .CORE_DONE(CORE_DONE), .CORE_RESULT(CORE_RESULT),
        .LOW_POWER_SELECT(LOW_POWER_SELECT), .CLOCK_DIVIDE_SELECT(CLOCK_DIVIDE_SELECT),
        .LONG_SAMPLE_SELECT(LONG_SAMPLE_SELECT), .CONVERSION_MODE(CONVERSION_MODE),
        .INPUT_CLOCK_SELECT(INPUT_CLOCK_SELECT), .RESULT_VALID(RESULT_VALID),
        .ALTERNATE_CLOCK(ALTERNATE_CLOCK), .ASYNC_CONVERTER_CLOCK(ASYNC_CONVERTER_CLOCK),
        .CONVERTER_CLOCK(CONVERTER_CLOCK), .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE),
        .PORT_PULLUP(PORT_PULLUP), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
        .PIN_PULLUP(PIN_PULLUP), .PORT_IN(PORT_IN));
    arc_core_model core (.MCLK(MCLK), .RST(RST), .START(START), .LATENCY(LATENCY),
        .VALUE(VALUE), .CORE_DONE(CORE_DONE), .CORE_RESULT(CORE_RESULT));

    // ==========================================================
    // clocks; the two side clocks are kept out of step with MCLK
    always #5 MCLK = ~MCLK;
    always #20 ALTERNATE_CLOCK = ~ALTERNATE_CLOCK;
    always #30 ASYNC_CONVERTER_CLOCK = ~ASYNC_CONVERTER_CLOCK;

    task automatic close_out;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // ==========================================================
    // bus access: request held until waitrequest is sampled low
    task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge MCLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= {24'h0, d};
        AVS_READ <= ~wr;
        AVS_WRITE <= wr;
        do begin
            @(posedge MCLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA[7:0];
        e = AVS_RESPONSE_ERR;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk({8'h00, q}, {8'h00, exp});
    endtask

    task automatic conv(input logic [9:0] v, input logic [3:0] l);
        @(posedge MCLK);
        START <= 1'b1;
        VALUE <= v;
        LATENCY <= l;
        @(posedge MCLK);
        START <= 1'b0;
        do begin
            @(posedge MCLK);
        end while (CORE_DONE !== 1'b1);
        @(posedge MCLK);
    endtask

    // counts converter clock pulses over 96 cycles; one pulse of slack for phase
    task automatic clkcnt(input logic [7:0] cfg, input int exp);
        int n;
        n = 0;
        acc(1'b1, arc_pkg::OFF_CONFIG, cfg);
        repeat (8) @(posedge MCLK);
        for (int i = 0; i < 96; i++) begin
            @(posedge MCLK);
            if (CONVERTER_CLOCK === 1'b1) n++;
        end
        chk({15'h0, (n >= exp - 1 && n <= exp + 1)}, 16'h0001);
    endtask

    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        repeat (12) @(posedge MCLK);
        RST <= 1'b0;
        for (int a = 0; a < 32; a += 4) rdchk(a[4:0], 8'h00);
        chk({15'h0, e}, 16'h0000);
        rdchk(5'h01, 8'h00);
        chk({15'h0, e}, 16'h0001);
        chk({14'h0, INPUT_CLOCK_SELECT}, {14'h0, arc_pkg::ICLK_BUS});
        foreach (cfg_tab[i]) begin
            acc(1'b1, arc_pkg::OFF_CONFIG, cfg_tab[i]);
            rdchk(arc_pkg::OFF_CONFIG, cfg_tab[i]);
            chk({8'h00, LOW_POWER_SELECT, CLOCK_DIVIDE_SELECT, LONG_SAMPLE_SELECT,
                 CONVERSION_MODE, INPUT_CLOCK_SELECT}, {8'h00, cfg_tab[i]});
        end
        foreach (clk_cfg[i]) clkcnt(clk_cfg[i], clk_exp[i]);
        // 8-bit mode: upper core bits must not leak into result_high
        acc(1'b1, arc_pkg::OFF_CONFIG, 8'h00);
        conv(10'h3A5, 4'h5);
        chk({15'h0, RESULT_VALID}, 16'h0001);
        rdchk(arc_pkg::OFF_CMP_CTRL, 8'h04);
        rdchk(arc_pkg::OFF_RES_HIGH, 8'h00);
        conv(10'h05A, 4'h0);
        rdchk(arc_pkg::OFF_RES_LOW, 8'h5A);
        acc(1'b1, arc_pkg::OFF_CONFIG, 8'h08);
        @(posedge MCLK);
        chk({15'h0, RESULT_VALID}, 16'h0000);
        // 10-bit interlock: result_high read blocks until result_low read
        conv(10'h2C3, 4'h3);
        rdchk(arc_pkg::OFF_RES_HIGH, 8'h02);
        conv(10'h155, 4'h0);
        rdchk(arc_pkg::OFF_RES_LOW, 8'hC3);
        conv(10'h0FF, 4'h2);
        rdchk(arc_pkg::OFF_RES_HIGH, 8'h00);
        rdchk(arc_pkg::OFF_RES_LOW, 8'hFF);
        // compare value 0x100, first below then greater-or-equal
        acc(1'b1, arc_pkg::OFF_CMP_HIGH, 8'h01);
        acc(1'b1, arc_pkg::OFF_CMP_LOW, 8'h00);
        acc(1'b1, arc_pkg::OFF_CMP_CTRL, 8'h01);
        conv(10'h0FE, 4'h1);
        conv(10'h200, 4'h1);
        rdchk(arc_pkg::OFF_RES_HIGH, 8'h00);
        rdchk(arc_pkg::OFF_RES_LOW, 8'hFE);
        acc(1'b1, arc_pkg::OFF_CMP_CTRL, 8'h03);
        conv(10'h100, 4'h1);
        conv(10'h0FF, 4'h1);
        rdchk(arc_pkg::OFF_RES_HIGH, 8'h01);
        rdchk(arc_pkg::OFF_RES_LOW, 8'h00);
        // 8-bit compare: high compare bits set but must be ignored; the high read
        // arms the lock, which the mode change must drop
        rdchk(arc_pkg::OFF_RES_HIGH, 8'h01);
        acc(1'b1, arc_pkg::OFF_CONFIG, 8'h00);
        acc(1'b1, arc_pkg::OFF_CMP_HIGH, 8'h03);
        acc(1'b1, arc_pkg::OFF_CMP_LOW, 8'h80);
        conv(10'h090, 4'h1);
        conv(10'h010, 4'h1);
        rdchk(arc_pkg::OFF_RES_LOW, 8'h90);
        acc(1'b1, arc_pkg::OFF_CMP_CTRL, 8'h00);
        // pin detach: channels 0-3 and 12-15
        chk(PIN_OE, 16'hFFFF);
        chk(PIN_OUT, 16'hA5A5);
        acc(1'b1, arc_pkg::OFF_PIN_BANK0, 8'h0F);
        acc(1'b1, arc_pkg::OFF_PIN_BANK1, 8'hF0);
        rdchk(arc_pkg::OFF_PIN_BANK1, 8'hF0);
        @(posedge MCLK);
        chk(PIN_OE, 16'h0FF0);
        chk(PIN_PULLUP, 16'h0FF0);
        chk(PORT_IN, 16'h0FF0);
        close_out();
    end
endmodule
